//--- core/dirq_router.sv
// dirq_router: onboard request sources, source map and dual prioritised controllers
`timescale 1ns/1ps
`default_nettype none
module dirq_router (
    input wire logic mclk,
    input wire logic rst,
    // serial port status pins, active high levels
    input wire logic [1:0] rx_byte_available,
    input wire logic [1:0] tx_holding_free,
    input wire logic [1:0] tx_char_done,
    input wire logic [1:0] dsr_in,
    input wire logic [1:0] dcd_in,
    // parallel ports
    input wire logic [1:0] par_in_strobe,
    input wire logic [1:0] par_in_read,
    input wire logic [1:0] peripheral_receipt_ack,
    input wire logic [1:0] par_out_write,
    output logic [1:0] par_in_full,
    output logic [1:0] par_out_acked,
    // polarity-adjusted control lines, active high requests
    input wire logic [7:0] ctrl_line_req,
    // map: level l takes source source_level_map[l*4 +: 4], SRC_NONE leaves it idle
    input wire logic [39:0] source_level_map,
    input wire dirq_pkg::dirq_cfg_s cfg,
    // software enables and masks
    input wire logic enable_a,
    input wire logic enable_b,
    input wire logic [7:0] mask_a,
    input wire logic [7:0] mask_b,
    // acknowledge
    input wire logic sinta,
    input wire logic resp_read,
    input wire logic [7:0] resp_byte_a,
    input wire logic [7:0] resp_byte_b,
    output logic [7:0] resp_data,
    output logic resp_valid,
    output dirq_pkg::dirq_bus_irq_s bus_irq,
    output logic [9:0] onboard_src_n,
    output logic [7:0] pending_a,
    output logic [7:0] pending_b,
    output logic ack_steer_select
);
    logic [1:0] rx_s, tx_s, done_s, dsr_s, dcd_s;
    logic [1:0] pstb_s, pack_s;
    logic [7:0] ctrl_s;
    logic [1:0] pstb_q, pack_q, dsr_q, dcd_q, done_q;
    logic [1:0] modem_chg_q;
    logic [1:0] out_written_q;
    logic [9:0] src_act;
    logic [7:0] req_b;
    logic [7:0] isr_a_q, isr_b_q;
    logic [7:0] act_a, act_b;
    logic any_a, any_b;
    logic [2:0] idx_a, idx_b;
    dirq_pkg::dirq_cfg_s cfg_q;
    logic [39:0] map_q;
    logic idle;
    logic ack_ev;
    logic ack_a_wins;

    dirq_sync #(.W(22)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({rx_byte_available, tx_holding_free, tx_char_done, dsr_in, dcd_in,
                   par_in_strobe, peripheral_receipt_ack, ctrl_line_req}),
        .sync_out({rx_s, tx_s, done_s, dsr_s, dcd_s, pstb_s, pack_s, ctrl_s})
    );

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pstb_q <= '0;
            pack_q <= '0;
            dsr_q <= '0;
            dcd_q <= '0;
            done_q <= '0;
        end
        else
        begin
            pstb_q <= pstb_s;
            pack_q <= pack_s;
            dsr_q <= dsr_s;
            dcd_q <= dcd_s;
            done_q <= done_s;
        end
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            // modem change and transmitter-done latch; cleared when byte accepted again
            always_ff @(posedge mclk)
            begin
                if (rst)
                    modem_chg_q[p] <= 1'b0;
                else if ((dsr_s[p] != dsr_q[p]) || (dcd_s[p] != dcd_q[p]) || (done_s[p] && !done_q[p]))
                    modem_chg_q[p] <= 1'b1;
                else if (!tx_s[p] && !done_s[p])
                    modem_chg_q[p] <= 1'b0;
            end
            // set wins over a read in the same cycle
            always_ff @(posedge mclk)
            begin
                if (rst)
                    par_in_full[p] <= 1'b0;
                else if (pstb_s[p] && !pstb_q[p])
                    par_in_full[p] <= 1'b1;
                else if (par_in_read[p])
                    par_in_full[p] <= 1'b0;
            end
            always_ff @(posedge mclk)
            begin
                if (rst)
                    out_written_q[p] <= 1'b0;
                else if (par_out_write[p])
                    out_written_q[p] <= 1'b1;
                else if (pack_s[p] && !pack_q[p])
                    out_written_q[p] <= 1'b0;
            end
            // only a receipt after a write counts
            always_ff @(posedge mclk)
            begin
                if (rst)
                    par_out_acked[p] <= 1'b0;
                else if (pack_s[p] && !pack_q[p] && out_written_q[p])
                    par_out_acked[p] <= 1'b1;
                else if (par_out_write[p])
                    par_out_acked[p] <= 1'b0;
            end
        end
    endgenerate

    always_comb
    begin
        src_act[1:0] = rx_s;
        src_act[3:2] = tx_s;
        src_act[5:4] = modem_chg_q | done_s;
        src_act[7:6] = par_in_full;
        src_act[9:8] = par_out_acked;
    end

    // sources cross the map as active-low levels
    always_ff @(posedge mclk)
    begin
        if (rst)
            onboard_src_n <= 10'h3ff;
        else
            onboard_src_n <= ~src_act;
    end

    genvar l;
    generate
        for (l = 0; l < 8; l++)
        begin : g_lvl
            logic [3:0] sel;
            assign sel = map_q[l*4 +: 4];
            assign req_b[l] = (sel < 4'(dirq_pkg::NUM_SRC)) ? ~onboard_src_n[sel] : 1'b0;
        end
    endgenerate

    assign idle = (isr_a_q == 8'h00) && (isr_b_q == 8'h00) && !any_a && !any_b;

    // configuration only moves while nothing is pending or in service
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cfg_q <= '0;
            map_q <= {10{dirq_pkg::SRC_NONE}};
        end
        else if (idle)
        begin
            cfg_q <= cfg;
            map_q <= source_level_map;
        end
    end

    // controller A on control lines, input 0 highest
    assign act_a = enable_a ? (ctrl_s & mask_a) : 8'h00;
    assign act_b = enable_b ? (req_b & mask_b) : 8'h00;
    assign pending_a = act_a;
    assign pending_b = act_b;

    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--)
            if (v[i])
                r = 3'(i);
        return r;
    endfunction

    assign any_a = (act_a != 8'h00) && (isr_a_q == 8'h00);
    assign any_b = (act_b != 8'h00) && (isr_b_q == 8'h00);
    assign idx_a = first_set(act_a);
    assign idx_b = first_set(act_b);

    // one combined 16-level winner in cascade, per-controller winners otherwise
    always_comb
    begin
        if (cfg_q.cascaded)
            ack_a_wins = cfg_q.a_over_b ? any_a : (any_a && !any_b);
        else
            ack_a_wins = any_a;
    end

    assign ack_steer_select = !cfg_q.cascaded;

    // sinta honoured only when sinta_resp is set, resp_read otherwise
    assign ack_ev = (cfg_q.sinta_resp && sinta) || (!cfg_q.sinta_resp && resp_read);

    // in-service bits; common acknowledge in cascade, steered in independent
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            isr_a_q <= 8'h00;
            isr_b_q <= 8'h00;
            resp_data <= dirq_pkg::RESP_IDLE;
            resp_valid <= 1'b0;
        end
        else
        begin
            resp_valid <= 1'b0;
            if (ack_ev && (any_a || any_b))
            begin
                resp_valid <= 1'b1;
                if (ack_a_wins)
                begin
                    isr_a_q <= 8'h01 << idx_a;
                    resp_data <= resp_byte_a;
                end
                else
                begin
                    isr_b_q <= 8'h01 << idx_b;
                    resp_data <= resp_byte_b;
                end
            end
            else if (ack_ev)
            begin
                // a second acknowledge ends service
                isr_a_q <= 8'h00;
                isr_b_q <= 8'h00;
            end
        end
    end

    // bus line drive
    always_ff @(posedge mclk)
    begin
        if (rst)
            bus_irq <= '0;
        else
        begin
            bus_irq <= '0;
            if (cfg_q.cascaded)
            begin
                if (cfg_q.use_pint)
                    bus_irq.pint <= any_a || any_b;
                else
                    bus_irq.vi[cfg_q.vi_sel_a] <= any_a || any_b;
            end
            else
            begin
                bus_irq.vi[cfg_q.vi_sel_a] <= any_a;
                if (any_b)
                    bus_irq.vi[cfg_q.vi_sel_b] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- core/dirq_pkg.sv
// dirq_pkg: shared constants and carrier types for the interrupt source router
package dirq_pkg;
    localparam int NUM_SRC = 10;
    localparam int NUM_LVL = 8;
    localparam int NUM_SER = 2;
    localparam int NUM_PAR = 2;
    localparam int SRC_W = 4;
    localparam int LVL_W = 3;
    // source numbering into the map
    localparam logic [3:0] SRC_RX_BASE = 4'h0;
    localparam logic [3:0] SRC_TX_BASE = 4'h2;
    localparam logic [3:0] SRC_IDLE_BASE = 4'h4;
    localparam logic [3:0] SRC_PIN_BASE = 4'h6;
    localparam logic [3:0] SRC_POUT_BASE = 4'h8;
    localparam logic [3:0] SRC_NONE = 4'hf;
    localparam logic [7:0] RESP_IDLE = 8'hff;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic cascaded;
        logic a_over_b;
        logic use_pint;
        logic sinta_resp;
        logic [2:0] vi_sel_a;
        logic [2:0] vi_sel_b;
    } dirq_cfg_s;

    typedef struct packed {
        logic pint;
        logic [7:0] vi;
    } dirq_bus_irq_s;
endpackage

//--- core/dirq_sync.sv
// dirq_sync: three-stage synchroniser with second/third stage agreement per bit
`timescale 1ns/1ps
`default_nettype none
module dirq_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // a change counts only once stages two and three agree
            always_ff @(posedge mclk)
            begin
                if (rst)
                    sync_out[i] <= 1'b0;
                else if (s2_q[i] == s3_q[i])
                    sync_out[i] <= s3_q[i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- tb/dirq_router_chk.sv
// concurrent checks on the interrupt source router ports
`timescale 1ns/1ps
`default_nettype none
module dirq_router_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] par_in_strobe,
    input wire logic [1:0] par_in_read,
    input wire logic [1:0] par_out_write,
    input wire logic [1:0] par_in_full,
    input wire logic [1:0] par_out_acked,
    input wire logic [9:0] onboard_src_n,
    input wire dirq_pkg::dirq_cfg_s cfg,
    input wire logic enable_a,
    input wire logic enable_b,
    input wire logic sinta,
    input wire logic resp_read,
    input wire logic resp_valid,
    input wire dirq_pkg::dirq_bus_irq_s bus_irq,
    input wire logic ack_steer_select
);
    logic ack_ev;
    // the acknowledge that counts depends on the response mode
    assign ack_ev = cfg.sinta_resp ? sinta : resp_read;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_pin_hold; par_in_full[0] && !par_in_read[0] |=> par_in_full[0]; endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("input full flag lost");
    property p_pout_hold; par_out_acked[0] && !par_out_write[0] |=> par_out_acked[0]; endproperty
    a_pout_hold: assert property (p_pout_hold) else $error("output acked flag lost");
    property p_pin_set; $rose(par_in_strobe[0]) |-> ##[1:6] par_in_full[0]; endproperty
    a_pin_set: assert property (p_pin_set) else $error("input full flag not set");
    property p_src_lo; par_in_full[0] |-> ##[0:2] !onboard_src_n[6]; endproperty
    a_src_lo: assert property (p_src_lo) else $error("source line not low");
    property p_valid_cause; resp_valid |-> $past(ack_ev); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("response without acknowledge");
    property p_sinta_ign; !cfg.sinta_resp && sinta && !resp_read |=> !resp_valid; endproperty
    a_sinta_ign: assert property (p_sinta_ign) else $error("bus acknowledge not ignored");
    property p_one_line; !ack_steer_select |-> $countones({bus_irq.pint, bus_irq.vi}) <= 1; endproperty
    a_one_line: assert property (p_one_line) else $error("cascade drives several lines");
    property p_indep; ack_steer_select |-> !bus_irq.pint && $countones(bus_irq.vi) <= 2; endproperty
    a_indep: assert property (p_indep) else $error("independent line use wrong");
    property p_irq_en; bus_irq != '0 |-> $past(enable_a) || $past(enable_b); endproperty
    a_irq_en: assert property (p_irq_en) else $error("request while disabled");
endmodule
bind dirq_router dirq_router_chk chk_u (.*);
`default_nettype wire

//--- tb/dirq_host_model.sv
// host cpu model: acknowledges requests, reads the response, then ends service
`timescale 1ns/1ps
`default_nettype none
module dirq_host_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic use_sinta,
    input wire logic [3:0] lag,
    input wire dirq_pkg::dirq_bus_irq_s bus_irq,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    output logic sinta,
    output logic resp_read,
    output logic [7:0] got,
    output int got_cnt
);
    task automatic ack_pulse();
        @(negedge mclk);
        sinta = use_sinta;
        resp_read = !use_sinta;
        @(negedge mclk);
        sinta = 1'b0;
        resp_read = 1'b0;
    endtask
    initial
    begin
        sinta = 1'b0;
        resp_read = 1'b0;
        got = 8'hff;
        got_cnt = 0;
        forever
        begin
            @(negedge mclk);
            // any raised line is served; outside prioritising is one line at a time
            if (go && !rst && bus_irq != '0)
            begin
                repeat (lag) @(negedge mclk);
                ack_pulse();
                // resp_valid stands one cycle, so look before the next edge passes
                for (int i = 0; i < 4; i++)
                begin
                    if (resp_valid)
                    begin
                        got = resp_data;
                        got_cnt++;
                        break;
                    end
                    @(negedge mclk);
                end
                repeat (8) @(negedge mclk);
                ack_pulse();
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the interrupt source router
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic cas;
        logic pint;
        logic [2:0] va;
        logic [7:0] req;
        logic [8:0] exp;
    } dirq_row_s;
    dirq_row_s rows [4] = '{'{1'b0, 1'b0, 3'h5, 8'h01, 9'h020}, '{1'b0, 1'b0, 3'h3, 8'h80, 9'h008},
        '{1'b1, 1'b1, 3'h0, 8'h04, 9'h100}, '{1'b1, 1'b0, 3'h4, 8'h10, 9'h010}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] rx = 2'h0, txh = 2'h0, txd = 2'h0, pstb = 2'h0, prd = 2'h0, pack = 2'h0, pwr = 2'h0;
    logic [1:0] par_in_full, par_out_acked;
    logic [7:0] ctrl_line_req = 8'h00, mask_a = 8'hff, mask_b = 8'h00, resp_byte_a = 8'h00, resp_data, got;
    logic [39:0] source_level_map = 40'hffffffffff;
    dirq_pkg::dirq_cfg_s cfg = '0;
    dirq_pkg::dirq_bus_irq_s bus_irq;
    logic enable_a = 1'b1, enable_b = 1'b0, sinta, resp_read, resp_valid, go = 1'b0, use_sinta = 1'b0;
    logic [3:0] lag = 4'h0;
    logic [9:0] onboard_src_n;
    int fail_count = 0, checks_done = 0, got_cnt, n, i;
    always #20 mclk = ~mclk;
    dirq_router dut_u (.mclk(mclk), .rst(rst), .rx_byte_available(rx), .tx_holding_free(txh),
        .tx_char_done(txd), .dsr_in(2'h0), .dcd_in(2'h0), .par_in_strobe(pstb), .par_in_read(prd),
        .peripheral_receipt_ack(pack), .par_out_write(pwr), .par_in_full(par_in_full),
        .par_out_acked(par_out_acked), .ctrl_line_req(ctrl_line_req), .source_level_map(source_level_map),
        .cfg(cfg), .enable_a(enable_a), .enable_b(enable_b), .mask_a(mask_a), .mask_b(mask_b), .sinta(sinta),
        .resp_read(resp_read), .resp_byte_a(resp_byte_a), .resp_byte_b(8'h5a), .resp_data(resp_data),
        .resp_valid(resp_valid), .bus_irq(bus_irq), .onboard_src_n(onboard_src_n), .pending_a(),
        .pending_b(), .ack_steer_select());
    dirq_host_model host_u (.mclk(mclk), .rst(rst), .go(go), .use_sinta(use_sinta), .lag(lag),
        .bus_irq(bus_irq), .resp_valid(resp_valid), .resp_data(resp_data), .sinta(sinta),
        .resp_read(resp_read), .got(got), .got_cnt(got_cnt));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    // bounded waits: running out is a mismatch and ends the run
    task automatic wait_irq();
        for (i = 0; i < 30 && bus_irq == '0; i++) cyc(1);
        if (i == 30)
        begin
            fail_count++;
            end_sim();
        end
    endtask
    initial
    begin
        cyc(2);
        rst = 1'b0;
        for (int r = 0; r < 4; r++)
        begin
            cfg = '{rows[r].cas, rows[r].cas, rows[r].pint, rows[r].pint, rows[r].va, 3'h2};
            use_sinta = rows[r].pint;
            lag = 4'(r * 3);
            resp_byte_a = 8'h10 + 8'(r);
            cyc(4);
            ctrl_line_req = rows[r].req;
            wait_irq();
            chk(bus_irq, rows[r].exp);
            n = got_cnt;
            go = 1'b1;
            for (i = 0; i < 60 && got_cnt == n; i++) cyc(1);
            if (i == 60)
            begin
                fail_count++;
                end_sim();
            end
            chk(got, 8'h10 + 8'(r));
            go = 1'b0;
            ctrl_line_req = 8'h00;
            cyc(16);
            chk(bus_irq, 9'h000);
            $display("row %0d done", r);
        end
        cfg = '0;
        use_sinta = 1'b1;
        ctrl_line_req = 8'h01;
        wait_irq();
        n = got_cnt;
        go = 1'b1;
        cyc(20);
        go = 1'b0;
        chk(got_cnt, n);
        chk(bus_irq, 9'h001);
        ctrl_line_req = 8'h00;
        enable_a = 1'b0;
        enable_b = 1'b1;
        mask_b = 8'h01;
        cfg.vi_sel_b = 3'h2;
        source_level_map = 40'hfffffffff6;
        cyc(6);
        pstb = 2'h1;
        wait_irq();
        chk(bus_irq, 9'h004);
        chk(par_in_full, 2'h1);
        chk(onboard_src_n, 10'h3bf);
        prd = 2'h1;
        cyc(1);
        prd = 2'h0;
        cyc(1);
        chk(par_in_full, 2'h0);
        $display("map and input port done");
        pwr = 2'h2;
        cyc(1);
        pwr = 2'h0;
        pack = 2'h2;
        cyc(6);
        chk(par_out_acked, 2'h2);
        pwr = 2'h2;
        cyc(1);
        pwr = 2'h0;
        cyc(1);
        chk(par_out_acked, 2'h0);
        rx = 2'h2;
        txh = 2'h1;
        txd = 2'h2;
        cyc(6);
        chk(onboard_src_n[5:0], 6'h19);
        $display("ports done");
        enable_b = 1'b0;
        ctrl_line_req = 8'hff;
        pstb = 2'h0;
        cyc(8);
        chk(bus_irq, 9'h000);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        chk({onboard_src_n, resp_data, par_in_full, par_out_acked}, {10'h3ff, 8'hff, 4'h0});
        $display("reset done");
        end_sim();
    end
endmodule
`default_nettype wire
